// >>> verilog/eq_ctrl_pkg.sv
// Package for the equalizer override and mode control block.
// Assumes a single 50 MHz system clock and a serial register link sampled on it.
`default_nettype none

package eq_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the serial link
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_DEVICE_ID = 7'h00;
    localparam logic [6:0] ADDR_STATUS = 7'h01;
    localparam logic [6:0] ADDR_MANUAL_LEN = 7'h02;
    localparam logic [6:0] ADDR_PIN_OVR = 7'h04;
    localparam logic [6:0] ADDR_EQ_CTRL = 7'h05;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HOLD_SEL_BIT = 0;
    localparam int HOLD_VAL_BIT = 1;
    localparam int OFF_SEL_BIT = 2;
    localparam int OFF_VAL_BIT = 3;
    localparam int COLOUR_SEL_BIT = 4;
    localparam int COLOUR_VAL_BIT = 5;
    localparam int INVERT_SEL_BIT = 6;
    localparam int INVERT_VAL_BIT = 7;
    localparam int LOCK_MODE_LSB = 0;
    localparam int NOISE_LSB = 2;
    localparam int CABLE_TYPE_BIT = 4;
    localparam int RW_BIT = 7;
    localparam int LEN_W = 6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PIN_OVR_RESET = 8'h00;
    localparam logic [7:0] EQ_CTRL_RESET = 8'h00;
    localparam logic [5:0] MANUAL_LEN_RESET = 6'h00;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] LOCK_CONT = 2'h0;
    localparam logic [1:0] LOCK_UNTIL_LOSS = 2'h1;
    localparam logic [1:0] LOCK_UNTIL_RESET = 2'h2;
    localparam logic [1:0] LOCK_MANUAL = 2'h3;
    localparam logic [1:0] NOISE_NONE = 2'h0;
    localparam logic [1:0] NOISE_MIN = 2'h1;
    localparam logic [1:0] NOISE_MAX = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int LOSS_TIME_MS = 1;
    localparam int LOSS_CYCLES = LOSS_TIME_MS * CLK_FREQ_KHZ;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 8;

    typedef enum logic [1:0] {
        SER_ADDR,
        SER_DATA,
        SER_DONE
    } ser_state_e;

endpackage

`default_nettype wire

// >>> verilog/loss_timer.sv
// Signal-absence timer for the lock-until-signal-loss mode.
// Assumes its enable is a synchronous level on the same clock.
`default_nettype none

module loss_timer #(
    parameter int LOSS_CYCLES = 50000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic count_en,
    // Result
    output logic loss_pulse
);
    import eq_ctrl_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic fired;
        logic pulse;
    } timer_s;

    timer_s q;
    timer_s n;

    // Counts absence cycles and fires once when the minimum absence is reached.
    always_comb begin
        n = q;
        n.pulse = 1'b0;
        if (!count_en) begin
            n.cnt = 32'h0;
            n.fired = 1'b0;
        end else if (!q.fired) begin
            if (q.cnt == 32'(LOSS_CYCLES - 1)) begin
                n.pulse = 1'b1;
                n.fired = 1'b1;
            end else begin
                n.cnt = q.cnt + 32'h1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign loss_pulse = q.pulse;

endmodule // loss_timer

`default_nettype wire

// >>> verilog/eq_override_ctrl.sv
// Pin-override and equalization-mode register bank with its serial register link.
// Assumes serial clock, data and select are synchronous to clk and far slower than it.
`default_nettype none

module eq_override_ctrl #(
    parameter int LOSS_CYCLES = eq_ctrl_pkg::LOSS_CYCLES,
    // Identification value; arbitrary.
    parameter logic [7:0] DEVICE_ID_VALUE = 8'hA5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial register link
    input wire logic serial_clk,
    input wire logic serial_sel_n,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Control pins
    input wire logic hold_pin,
    input wire logic eq_off_pin,
    input wire logic colour_pin,
    input wire logic invert_pin,
    // Equalizer status
    input wire logic signal_present,
    input wire logic eq_settled,
    // Effective controls to the equalizer
    output logic eq_freeze,
    output logic eq_off,
    output logic colour_mode,
    output logic invert_input,
    output logic auto_polarity_en,
    output logic [1:0] lock_mode,
    output logic [1:0] noise_level,
    output logic cable_coax,
    output logic manual_len_en,
    output logic [eq_ctrl_pkg::LEN_W-1:0] manual_length,
    output logic restart_eq
);
    import eq_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ser_clk_prev;
        ser_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rd;
        logic [6:0] addr;
        logic data_out;
        logic data_oe;
        logic [7:0] pin_ovr;
        logic [7:0] eq_ctrl;
        logic [LEN_W-1:0] man_len;
        logic locked;
        logic eq_freeze;
        logic eq_off;
        logic colour;
        logic invert;
        logic auto_pol;
        logic [1:0] lock_mode;
        logic [1:0] noise;
        logic coax;
        logic manual;
        logic [LEN_W-1:0] man_len_out;
        logic restart;
    } ctrl_s;

    ctrl_s q;
    ctrl_s n;
    logic loss_pulse;
    logic timer_en;

    // Returns the readable value at a register address; unmapped reads as zero.
    function automatic logic [7:0] reg_read(input logic [6:0] a, input ctrl_s s, input logic sig);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_DEVICE_ID: v = DEVICE_ID_VALUE;
            ADDR_STATUS: v = {6'h00, s.locked, sig};
            ADDR_MANUAL_LEN: v = {2'h0, s.man_len};
            ADDR_PIN_OVR: v = s.pin_ovr;
            ADDR_EQ_CTRL: v = {3'h0, s.eq_ctrl[4:0]};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Chooses between pin and software value for one override pair.
    function automatic logic pick(input logic sel, input logic val, input logic pin);
        return sel ? val : pin;
    endfunction

    // ------------------------------------------------------------------
    // Signal-loss timer
    // ------------------------------------------------------------------
    assign timer_en = (q.lock_mode == LOCK_UNTIL_LOSS) && q.locked && !signal_present;

    loss_timer #(
        .LOSS_CYCLES(LOSS_CYCLES)
    ) u_loss_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .count_en(timer_en),
        .loss_pulse(loss_pulse)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Serial link, register writes and derivation of the effective controls.
    always_comb begin
        logic ser_clk_rise;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic hold_src;
        logic [1:0] mode;
        logic [1:0] filt;
        ser_clk_rise = 1'b0;
        wdata = 8'h00;
        rdata = 8'h00;
        hold_src = 1'b0;
        mode = 2'h0;
        filt = 2'h0;
        n = q;
        n.restart = 1'b0;
        n.ser_clk_prev = serial_clk;
        ser_clk_rise = serial_clk && !q.ser_clk_prev;

        // Serial frame handling; a dropped select aborts the frame.
        if (serial_sel_n) begin
            n.state = SER_ADDR;
            n.bit_cnt = 4'h0;
            n.data_oe = 1'b0;
            n.data_out = 1'b0;
        end else if (ser_clk_rise) begin
            case (q.state)
                SER_ADDR: begin
                    n.shift = {q.shift[6:0], serial_data_line_in};
                    n.bit_cnt = q.bit_cnt + 4'h1;
                    if (q.bit_cnt == 4'(ADDR_BITS - 1)) begin
                        n.rd = q.shift[RW_BIT - 1];
                        n.addr = {q.shift[5:0], serial_data_line_in};
                        n.bit_cnt = 4'h0;
                        n.state = SER_DATA;
                    end
                end
                SER_DATA: begin
                    n.bit_cnt = q.bit_cnt + 4'h1;
                    if (q.rd) begin
                        if (q.bit_cnt == 4'h0) begin
                            rdata = reg_read(q.addr, q, signal_present);
                            n.data_out = rdata[7];
                            n.shift = {rdata[6:0], 1'b0};
                            n.data_oe = 1'b1;
                        end else begin
                            n.data_out = q.shift[7];
                            n.shift = {q.shift[6:0], 1'b0};
                        end
                    end else begin
                        n.shift = {q.shift[6:0], serial_data_line_in};
                    end
                    if (q.bit_cnt == 4'(DATA_BITS - 1)) begin
                        n.state = SER_DONE;
                        if (!q.rd) begin
                            wdata = {q.shift[6:0], serial_data_line_in};
                            case (q.addr)
                                ADDR_MANUAL_LEN: n.man_len = wdata[LEN_W-1:0];
                                ADDR_PIN_OVR: n.pin_ovr = wdata;
                                ADDR_EQ_CTRL: n.eq_ctrl = {3'h0, wdata[4:0]};
                                default: n.man_len = q.man_len;
                            endcase
                        end
                    end
                end
                SER_DONE: begin
                    // Last read bit held through its falling edge, then released.
                    n.data_oe = 1'b0;
                    n.data_out = 1'b0;
                end
                default: begin
                    n.state = SER_ADDR;
                end
            endcase
        end

        hold_src = pick(q.pin_ovr[HOLD_SEL_BIT], q.pin_ovr[HOLD_VAL_BIT], hold_pin);
        n.eq_off = pick(q.pin_ovr[OFF_SEL_BIT], q.pin_ovr[OFF_VAL_BIT], eq_off_pin);
        n.colour = pick(q.pin_ovr[COLOUR_SEL_BIT], q.pin_ovr[COLOUR_VAL_BIT], colour_pin);
        n.invert = pick(q.pin_ovr[INVERT_SEL_BIT], q.pin_ovr[INVERT_VAL_BIT], invert_pin);

        mode = q.eq_ctrl[LOCK_MODE_LSB +: 2];
        n.lock_mode = mode;
        n.manual = (mode == LOCK_MANUAL);
        n.auto_pol = (mode != LOCK_MANUAL);
        n.coax = (mode == LOCK_MANUAL) && q.eq_ctrl[CABLE_TYPE_BIT];
        n.man_len_out = (mode == LOCK_MANUAL) ? q.man_len : MANUAL_LEN_RESET;

        filt = q.eq_ctrl[NOISE_LSB +: 2];
        case (filt)
            2'h0: n.noise = NOISE_NONE;
            2'h1: n.noise = NOISE_MIN;
            default: n.noise = NOISE_MAX;
        endcase

        // Lock tracking per mode; the board keeps the hold pin low here.
        case (mode)
            LOCK_UNTIL_LOSS: begin
                if (loss_pulse) begin
                    n.locked = 1'b0;
                    n.restart = 1'b1;
                end else if (eq_settled) begin
                    n.locked = 1'b1;
                end
            end
            LOCK_UNTIL_RESET: begin
                if (eq_settled) begin
                    n.locked = 1'b1;
                end
            end
            default: n.locked = 1'b0;
        endcase

        n.eq_freeze = hold_src || q.locked;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // All state resets to constants; both control registers clear to zero.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.pin_ovr <= PIN_OVR_RESET;
            q.eq_ctrl <= EQ_CTRL_RESET;
            q.man_len <= MANUAL_LEN_RESET;
            q.state <= SER_ADDR;
            q.auto_pol <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a field of the state register.
    assign serial_data_line_out = q.data_out;
    assign serial_data_line_oe = q.data_oe;
    assign eq_freeze = q.eq_freeze;
    assign eq_off = q.eq_off;
    assign colour_mode = q.colour;
    assign invert_input = q.invert;
    assign auto_polarity_en = q.auto_pol;
    assign lock_mode = q.lock_mode;
    assign noise_level = q.noise;
    assign cable_coax = q.coax;
    assign manual_len_en = q.manual;
    assign manual_length = q.man_len_out;
    assign restart_eq = q.restart;

endmodule // eq_override_ctrl

`default_nettype wire

// >>> test/eq_override_ctrl_chk.sv
// Checker for the equalizer override and mode register bank.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none

module eq_override_ctrl_chk
    import eq_ctrl_pkg::*;
#(
    parameter int LOSS_CYCLES = 50000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial link
    input wire logic serial_sel_n,
    input wire logic serial_data_line_oe,
    // Status and controls
    input wire logic signal_present,
    input wire logic auto_polarity_en,
    input wire logic [1:0] lock_mode,
    input wire logic [1:0] noise_level,
    input wire logic cable_coax,
    input wire logic manual_len_en,
    input wire logic [eq_ctrl_pkg::LEN_W-1:0] manual_length,
    input wire logic restart_eq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------
    int absent_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Counts consecutive cycles without an input signal.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            absent_cnt <= 0;
        end else begin
            absent_cnt <= signal_present ? 0 : absent_cnt + 1;
        end
    end

    sequence s_pulse;
        restart_eq ##1 !restart_eq;
    endsequence

    property p_man_en;
        manual_len_en == (lock_mode == LOCK_MANUAL);
    endproperty
    property p_auto_pol;
        auto_polarity_en == !manual_len_en;
    endproperty
    property p_cable;
        cable_coax |-> manual_len_en;
    endproperty
    property p_len;
        (manual_length != '0) |-> manual_len_en;
    endproperty
    property p_noise;
        noise_level != 2'h3;
    endproperty
    property p_restart_mode;
        restart_eq |-> lock_mode == LOCK_UNTIL_LOSS;
    endproperty
    property p_restart_wait;
        restart_eq |-> $past(absent_cnt) >= LOSS_CYCLES - 1;
    endproperty
    property p_pulse;
        restart_eq |-> s_pulse;
    endproperty
    property p_release;
        $past(serial_sel_n) |-> !serial_data_line_oe;
    endproperty
    property p_write_only;
        $changed(lock_mode) |-> !$past(serial_sel_n, 2);
    endproperty

    a_man_en: assert property (p_man_en) else $error("manual enable differs from mode");
    a_auto_pol: assert property (p_auto_pol) else $error("polarity corrector wrong");
    a_cable: assert property (p_cable) else $error("cable bit used outside manual mode");
    a_len: assert property (p_len) else $error("length applied outside manual mode");
    a_noise: assert property (p_noise) else $error("noise level code out of range");
    a_restart_mode: assert property (p_restart_mode) else $error("restart in wrong mode");
    a_restart_wait: assert property (p_restart_wait) else $error("restart before absence time");
    a_pulse: assert property (p_pulse) else $error("restart longer than one cycle");
    a_release: assert property (p_release) else $error("data line driven without select");
    a_write_only: assert property (p_write_only) else $error("mode changed outside a frame");
endmodule // eq_override_ctrl_chk

bind eq_override_ctrl eq_override_ctrl_chk #(.LOSS_CYCLES(LOSS_CYCLES)) eq_override_ctrl_chk_i (
    .clk, .sys_rst, .serial_sel_n, .serial_data_line_oe, .signal_present, .auto_polarity_en,
    .lock_mode, .noise_level, .cable_coax, .manual_len_en, .manual_length, .restart_eq
);

`default_nettype wire

// >>> test/eq_host_model.sv
// Host microcontroller model driving the serial register link.
// Assumes the link is sampled on clk; the serial clock idles low.
`default_nettype none

module eq_host_model (
    // Clock
    input wire logic clk,
    // Serial link
    output logic serial_clk,
    output logic serial_sel_n,
    output logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    logic bit_v;

    assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out : (drv ? bit_v : ~bit_v);

    // Idle link state.
    initial begin
        serial_clk = 1'b0;
        serial_sel_n = 1'b1;
        drv = 1'b1;
        bit_v = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame of nrise clocks; fewer than 16 aborts it.
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, input int nrise, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {hdr, wd};
        rd = 8'h00;
        serial_sel_n = 1'b0;
        for (int i = 0; i < nrise; i++) begin
            drv = !(hdr[7] && i >= 8);
            bit_v = sh[15-i];
            wait_clk(3);
            serial_clk = 1'b1;
            wait_clk(3);
            serial_clk = 1'b0;
            if (!drv) begin
                rd = {rd[6:0], serial_data_line_in};
            end
        end
        wait_clk(2);
        serial_sel_n = 1'b1;
        drv = 1'b1;
        wait_clk(2);
    endtask
endmodule // eq_host_model

`default_nettype wire

// >>> test/tb_top.sv
// Testbench for the equalizer override and mode register bank.
// Assumes the package, host model and checker are compiled first.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eq_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int LOSS = 20;
    logic clk, sys_rst, serial_clk, serial_sel_n, serial_data_line_in, serial_data_line_out;
    logic serial_data_line_oe, hold_pin, eq_off_pin, colour_pin, invert_pin, signal_present;
    logic eq_settled, eq_freeze, eq_off, colour_mode, invert_input, auto_polarity_en;
    logic cable_coax, manual_len_en, restart_eq;
    logic [1:0] lock_mode, noise_level;
    logic [LEN_W-1:0] manual_length;
    logic [3:0] pins, ctl;
    logic [7:0] mode_v;
    int error_cnt, cmp_count, pulses;

    assign {invert_pin, colour_pin, eq_off_pin, hold_pin} = pins;
    assign ctl = {invert_input, colour_mode, eq_off, eq_freeze};
    assign mode_v = {1'b0, auto_polarity_en, manual_len_en, cable_coax, noise_level, lock_mode};

    eq_override_ctrl #(.LOSS_CYCLES(LOSS)) eq_override_ctrl_i (
        .clk, .sys_rst, .serial_clk, .serial_sel_n, .serial_data_line_in, .serial_data_line_out,
        .serial_data_line_oe, .hold_pin, .eq_off_pin, .colour_pin, .invert_pin, .signal_present,
        .eq_settled, .eq_freeze, .eq_off, .colour_mode, .invert_input, .auto_polarity_en, .lock_mode,
        .noise_level, .cable_coax, .manual_len_en, .manual_length, .restart_eq
    );
    eq_host_model eq_host_model_i (
        .clk, .serial_clk, .serial_sel_n, .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe
    );

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts restart pulses.
    always @(posedge clk) begin
        if (restart_eq === 1'b1) pulses++;
    end

    // Watchdog against a hung link.
    initial begin
        #1000000;
        error_cnt++;
        results();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp(got, exp, "register read");
    endtask
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        cmp(got, exp, "output");
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        eq_host_model_i.xfer({1'b0, a}, d, 16, r);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        eq_host_model_i.xfer({1'b1, a}, 8'h00, 16, r);
        chk_reg(r, e);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] ov, ev;
        logic [3:0] ex;
        logic [1:0] mm;
        int n;
        pins = 4'h0;
        signal_present = 1'b0;
        eq_settled = 1'b0;
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        rd_chk(ADDR_PIN_OVR, 8'h00);
        rd_chk(ADDR_EQ_CTRL, 8'h00);
        chk_out(mode_v, 8'h40);
        pins = 4'hF;
        tick(2);
        chk_out({4'h0, ctl}, 8'h0F);
        wr(ADDR_PIN_OVR, 8'hAA);
        pins = 4'h0;
        tick(2);
        chk_out({4'h0, ctl}, 8'h00);
        // Each source select against opposite pin levels.
        for (int k = 0; k < 4; k++) begin
            for (int v = 0; v < 2; v++) begin
                ov = 8'h01 << (2 * k);
                ov[2*k+1] = v[0];
                pins = v[0] ? 4'h0 : 4'hF;
                wr(ADDR_PIN_OVR, ov);
                ex = pins;
                ex[k] = v[0];
                chk_out({4'h0, ctl}, {4'h0, ex});
                rd_chk(ADDR_PIN_OVR, ov);
            end
        end
        // All locking modes and noise codes, cable bit set where odd.
        wr(ADDR_PIN_OVR, 8'h00);
        wr(ADDR_MANUAL_LEN, 8'h3F);
        for (int m = 0; m < 4; m++) begin
            mm = 2'(m);
            ev = {3'b111, mm[0], mm, mm};
            wr(ADDR_EQ_CTRL, ev);
            rd_chk(ADDR_EQ_CTRL, {3'b000, ev[4:0]});
            ov = {1'b0, mm != LOCK_MANUAL, mm == LOCK_MANUAL, mm == LOCK_MANUAL, (mm[1] ? NOISE_MAX : mm), mm};
            chk_out(mode_v, ov);
            chk_out({2'b00, manual_length}, (mm == LOCK_MANUAL) ? 8'h3F : 8'h00);
        end
        // Aborted frame and unmapped place.
        wr(ADDR_EQ_CTRL, 8'h00);
        eq_host_model_i.xfer({1'b0, ADDR_EQ_CTRL}, 8'h13, 12, ov);
        rd_chk(ADDR_EQ_CTRL, 8'h00);
        wr(7'h06, 8'hFF);
        rd_chk(7'h06, 8'h00);
        // Lock until loss with the hold pin held low.
        pins = 4'h0;
        signal_present = 1'b1;
        eq_settled = 1'b1;
        wr(ADDR_EQ_CTRL, {6'h00, LOCK_UNTIL_LOSS});
        chk_out({7'h00, eq_freeze}, 8'h01);
        signal_present = 1'b0;
        tick(LOSS / 2);
        signal_present = 1'b1;
        tick(4);
        chk_out(8'(pulses), 8'h00);
        signal_present = 1'b0;
        n = 0;
        while (restart_eq !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk_out(8'(n >= LOSS && n <= LOSS + 3), 8'h01);
        signal_present = 1'b1;
        wr(ADDR_EQ_CTRL, {6'h00, LOCK_UNTIL_RESET});
        n = pulses;
        signal_present = 1'b0;
        tick(3 * LOSS);
        chk_out(8'(pulses - n), 8'h00);
        chk_out({7'h00, eq_freeze}, 8'h01);
        rd_chk(ADDR_STATUS, 8'h02);
        // Second reset in mid-run clears both control registers.
        wr(ADDR_PIN_OVR, 8'h55);
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        rd_chk(ADDR_PIN_OVR, 8'h00);
        rd_chk(ADDR_EQ_CTRL, 8'h00);
        chk_out(mode_v, 8'h40);
        results();
    end
endmodule // tb_top

`default_nettype wire
